// [dv/audio_generator_editor_control_test.sv]
// Register and stream test of the audio generator/editor control block.
// Assumes the upstream source model and the 125 MHz core clock.
`timescale 1ns/1ps
`include "agen_params.svh"
module audio_generator_editor_control_test;
    import agen_pkg::*;
    logic       core_clk, rst_b, reg_wr, reg_rd, ref_coax, input_sync, src_run, coax_run;
    logic       ref_bal, bal_run;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    frame_t     rx_data, tx_data;
    logic       tx_strobe;
    int         err_total, check_count, gap, p, q;
    logic [23:0] s [5];
    logic [7:0] cfg [3] = '{8'h08, 8'h68, 8'hF8};
    int         ep [3] = '{1, 0, 2};
    int         en [3] = '{0, 3, 2};

    audio_generator_editor_control #(.LOSS_CYC(256)) u_audio_generator_editor_control (
        .core_clk_i(core_clk), .rst_b_i(rst_b), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .ref_bal_i(ref_bal), .ref_coax_i(ref_coax),
        .input_sync_i(input_sync), .rx_data_i(rx_data), .tx_data_o(tx_data),
        .tx_strobe_o(tx_strobe));
    audio_source_model u_audio_source_model (
        .run_i(src_run), .input_sync_o(input_sync), .rx_data_o(rx_data));

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Slow edges: about thirteen per internal period, so they read as word clock
    always #1600 ref_coax <= coax_run ? ~ref_coax : 1'b0;
    always #1600 ref_bal  <= bal_run ? ~ref_bal : 1'b0;

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk_reg(input string what, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(what, exp, v);
    endtask
    task automatic poll(input string what, input logic [7:0] mask, input logic [7:0] exp);
        logic [7:0] v;
        int i;
        for (i = 0; i < 10000; i++)
        begin
            rd(4'h4, v);
            if ((v & mask) === exp)
                break;
        end
        chk(what, exp, v & mask);
        if (i == 10000)
            wrap_up();
    endtask
    // Waits k strobes; gap holds the cycle count of the last one
    task automatic strobe(input int k);
        repeat (k)
        begin
            gap = 0;
            do
            begin
                @(posedge core_clk);
                #1 gap++;
            end
            while (tx_strobe !== 1'b1 && gap < 4000);
            if (gap >= 4000)
            begin
                chk("tx_strobe", 1, 0);
                wrap_up();
            end
        end
    endtask

    initial
    begin
        {rst_b, reg_wr, reg_rd, ref_coax, ref_bal, src_run, coax_run, bal_run} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        chk_reg("sync reset", 4'h0, 8'h00);
        chk_reg("edit reset", 4'h1, 8'h00);
        chk_reg("unmapped", 4'hF, 8'h00);
        strobe(1);
        chk("black out", 0, tx_data);
        strobe(1);
        chk("period 48k", `DIV_48K, gap);
        wr(4'h0, 8'h04);
        strobe(2);
        chk("period 44k1", `DIV_44K1, gap);
        $display("test internal done");
        coax_run = 1'b1;
        wr(4'h0, 8'h01);
        poll("ref status", 8'h1F, 8'h0E);
        bal_run = 1'b1;
        poll("bal status", 8'h07, 8'h07);
        coax_run = 1'b0;
        bal_run = 1'b0;
        src_run = 1'b1;
        wr(4'h0, 8'h03);
        poll("input status", 8'h38, 8'h38);
        strobe(1);
        chk("pass through", rx_data, tx_data);
        $display("test sync done");
        wr(4'h1, 8'h02);
        for (int k = 0; k < 3; k++)
        begin
            wr(4'h2, cfg[k]);
            strobe(2);
            p = 0;
            q = 0;
            repeat (192)
            begin
                strobe(1);
                p += (tx_data.a.audio === `FS_POS);
                q += (tx_data.a.audio === `FS_NEG);
            end
            chk("pulse pos", ep[k], p);
            chk("pulse neg", en[k], q);
        end
        $display("test pulse done");
        wr(4'h1, 8'h0C);
        wr(4'h3, 8'h03);
        wr(4'h1, 8'h1D);
        wr(4'h3, 8'h00);
        chk_reg("value b", 4'h3, 8'h00);
        strobe(2);
        chk("split bits", 4'b1100, {tx_data.a.cs, tx_data.a.v, tx_data.b.cs, tx_data.b.v});
        wr(4'h1, 8'h0C);
        wr(4'h1, 8'h1D);
        chk_reg("value copied", 4'h3, 8'h03);
        strobe(2);
        chk("copied bits", 4'b1111, {tx_data.a.cs, tx_data.a.v, tx_data.b.cs, tx_data.b.v});
        wr(4'h1, 8'h1F);
        wr(4'h2, 8'h06);
        wr(4'h1, 8'h0F);
        wr(4'h2, 8'h04);
        strobe(2);
        s[0] = tx_data.a.audio;
        s[1] = tx_data.b.audio;
        strobe(1);
        s[2] = tx_data.a.audio;
        s[3] = tx_data.b.audio;
        s[4] = s[2] - s[0];
        chk("ramp falling", 24'hFF_0000, 24'(s[3] - s[1]));
        chk("triangle step", 1, s[4] == 24'h02_0000 || s[4] == 24'hFE_0000 || s[4] == 24'h0);
        wr(4'h1, 8'h1C);
        $display("test split done");
        wr(4'h2, 8'h01);
        wr(4'h1, 8'h01);
        chk_reg("edit locked", 4'h1, 8'h1C);
        strobe(2);
        chk("channel_test_generator pass", rx_data, tx_data);
        src_run = 1'b0;
        poll("lost input", 8'h38, 8'h00);
        strobe(2);
        chk("fallback period", `DIV_48K, gap);
        wr(4'h0, 8'h00);
        strobe(2);
        for (int i = 0; i < 5; i++)
        begin
            strobe(1);
            s[i] = tx_data.a.audio;
        end
        chk("quarter repeat", s[0], s[4]);
        chk("quarter half", (s[0] == `FS_POS) ? `FS_NEG : ((s[0] == `FS_NEG) ? `FS_POS : 24'h0), s[2]);
        chk("quarter peak", 1, ((s[0] | s[1]) == `FS_POS || (s[0] | s[1]) == `FS_NEG) && (s[0] & s[1]) == 24'h0);
        wr(4'h2, 8'h03);
        strobe(2);
        s[0] = tx_data.a.audio;
        strobe(1);
        s[1] = tx_data.a.audio;
        chk("prs shift", s[0][22:1], s[1][23:2]);
        chk("prs live", 1, s[1] != s[0] && s[1] != 24'h0);
        $display("test channel_test_generator done");
        wr(4'h0, 8'h03);
        wr(4'h5, 8'h00);
        chk_reg("sync clear", 4'h0, 8'h00);
        chk_reg("edit clear", 4'h1, 8'h00);
        $display("test clear done");
        wrap_up();
    end
endmodule // audio_generator_editor_control_test

// [dv/audio_source_model.sv]
// Upstream audio source: frame clock on the link and received frames.
// Assumes the bench starts and stops it; link period is 125 ns.
`timescale 1ns/1ps
module audio_source_model
(
    input  wire logic        run_i,
    output logic             input_sync_o,
    output agen_pkg::frame_t rx_data_o
);
    import agen_pkg::*;
    logic [25:0] seq;
    initial
    begin
        input_sync_o = 1'b0;
        seq = 26'h000_0001;
        rx_data_o = '0;
        forever
        begin
            if (run_i === 1'b1)
            begin
                input_sync_o = 1'b1;
                #62.5;
                input_sync_o = 1'b0;
                // New frame far from the rising edge the block samples
                seq = seq * 26'h000_0005 + 26'h000_0003;
                rx_data_o = {seq, ~seq};
                #62.5;
            end
            else
            begin
                // Stopped link: clock stands still, data churns so it never looks valid
                rx_data_o = ~rx_data_o;
                #62.5;
            end
        end
    end
endmodule // audio_source_model

// [hdl/agen_params.svh]
// Constants for the audio generator/editor control block.
// Assumes a 125 MHz core clock and a byte-wide register port.
`ifndef AGEN_PARAMS_SVH
`define AGEN_PARAMS_SVH

`define CLK_HZ              125_000_000
`define RATE_48K_HZ         48_000
`define RATE_44K1_HZ        44_100
`define DIV_48K             (`CLK_HZ / `RATE_48K_HZ)
`define DIV_44K1            (`CLK_HZ / `RATE_44K1_HZ)
`define PULSE_PERIOD        192
`define AES_RISE_PER_FRAME  64
`define AES_MIN_EDGES       16
`define LOSS_CYC_DEF        8192
`define PRS_SEED            23'h00_0001
`define FS_POS              24'h7F_FFFF
`define FS_NEG              24'h80_0000
`define JT_LEVEL            24'h20_0000

`define ADDR_SYNC           4'h0
`define ADDR_EDIT           4'h1
`define ADDR_FUNC           4'h2
`define ADDR_VALUE          4'h3
`define ADDR_STATUS         4'h4
`define ADDR_CLEAR          4'h5

`define SYNC_RATE_BIT       2
`define EDIT_SPLIT_BIT      0
`define EDIT_AUD_BIT        1
`define EDIT_CS_BIT         2
`define EDIT_V_BIT          3
`define EDIT_CHANNEL_SELECT_BIT       4
`define SYNC_RST            8'h00
`define EDIT_RST            8'h00

`endif

// [hdl/agen_pkg.sv]
// Types for the audio generator/editor control block.
// Assumes agen_params.svh supplies all numeric constants.
package agen_pkg;

    typedef enum logic [1:0] {
        SYNC_INT   = 2'b00,
        SYNC_REF   = 2'b01,
        SYNC_INPUT = 2'b11
    } sync_mode_t;

    typedef enum logic [1:0] {
        POL_POS = 2'b00,
        POL_NEG = 2'b01,
        POL_BIP = 2'b11
    } pulse_pol_t;

    typedef struct packed {
        logic       cs_val;
        logic       v_val;
        pulse_pol_t pol;
        logic [1:0] width_m1;
        logic [2:0] func;
        logic       channel_test_generator;
    } sub_cfg_t;

    typedef struct packed {
        logic [23:0] audio;
        logic        cs;
        logic        v;
    } subframe_t;

    typedef struct packed {
        subframe_t a;
        subframe_t b;
    } frame_t;

endpackage

// [hdl/audio_generator_editor_control.sv]
// Sync selection, edit muxing and waveform generation for a two-subframe
// output stream. Assumes pins are asynchronous; rx_data_i is same-domain.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
`include "agen_params.svh"

module audio_generator_editor_control #(
    parameter int unsigned LOSS_CYC = `LOSS_CYC_DEF
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_b_i,
    input  wire logic [3:0]        reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic [7:0]             reg_rdata_o,
    input  wire logic              ref_bal_i,
    input  wire logic              ref_coax_i,
    input  wire logic              input_sync_i,
    input  agen_pkg::frame_t       rx_data_i,
    output agen_pkg::frame_t       tx_data_o,
    output logic                   tx_strobe_o
);
    import agen_pkg::*;

    localparam int LW = $clog2(LOSS_CYC + 1);

    // ------------------------------------------------------------
    // Pin synchronisers and activity sensing
    // ------------------------------------------------------------
    logic [2:0] pins_w;
    logic [2:0] rise_w;
    logic [2:0] edge_w;
    logic [2:0] pres_w;

    assign pins_w = {input_sync_i, ref_coax_i, ref_bal_i};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_pin
            logic          meta_r;
            logic          sync_r;
            logic          prev_r;
            logic          present_r;
            logic [LW-1:0] quiet_r;
            always_ff @(posedge core_clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                begin
                    meta_r    <= 1'b0;
                    sync_r    <= 1'b0;
                    prev_r    <= 1'b0;
                    present_r <= 1'b0;
                    quiet_r   <= '0;
                end
                else
                begin
                    meta_r <= pins_w[gi];
                    sync_r <= meta_r;
                    prev_r <= sync_r;
                    if (sync_r != prev_r)
                    begin
                        quiet_r   <= '0;
                        present_r <= 1'b1;
                    end
                    else if (quiet_r == LW'(LOSS_CYC - 1))
                        present_r <= 1'b0;
                    else
                        quiet_r <= quiet_r + 1'b1;
                end
            end
            assign rise_w[gi] = sync_r & ~prev_r;
            assign edge_w[gi] = sync_r ^ prev_r;
            assign pres_w[gi] = present_r;
        end
    endgenerate

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [7:0] sync_r;
    logic [7:0] edit_r;
    sub_cfg_t   cfg_a_r;
    sub_cfg_t   cfg_b_r;
    logic       channel_test_generator;
    logic       split_eff;
    logic       channel_select_b;
    logic       wr_a;
    logic       wr_b;
    logic       clr_wr;
    sync_mode_t mode_sel;

    assign channel_test_generator      = cfg_a_r.channel_test_generator;
    assign split_eff = edit_r[`EDIT_SPLIT_BIT] & ~channel_test_generator;
    assign channel_select_b    = edit_r[`EDIT_CHANNEL_SELECT_BIT];
    assign wr_a      = ~split_eff | ~channel_select_b;
    assign wr_b      = ~split_eff | channel_select_b;
    assign clr_wr    = reg_wr_i && reg_addr_i == `ADDR_CLEAR;
    assign mode_sel  = (sync_r[1:0] == 2'b10) ? SYNC_INT : sync_mode_t'(sync_r[1:0]);

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            sync_r <= `SYNC_RST;
        else if (clr_wr)
            sync_r <= `SYNC_RST;
        else if (reg_wr_i && reg_addr_i == `ADDR_SYNC)
            sync_r <= {5'h00, reg_wdata_i[2:0]};
    end

    // Edit settings stay frozen, except for a clear, while the second generator is active
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            edit_r <= `EDIT_RST;
        else if (clr_wr)
            edit_r <= `EDIT_RST;
        else if (reg_wr_i && reg_addr_i == `ADDR_EDIT && !channel_test_generator)
            edit_r <= {3'h0, reg_wdata_i[4:0]};
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cfg_a_r <= '0;
            cfg_b_r <= '0;
        end
        else if (reg_wr_i && reg_addr_i == `ADDR_EDIT && !channel_test_generator &&
                 reg_wdata_i[`EDIT_SPLIT_BIT] != edit_r[`EDIT_SPLIT_BIT])
            cfg_b_r <= cfg_a_r;
        else if (reg_wr_i && reg_addr_i == `ADDR_FUNC)
        begin
            if (wr_a)
                cfg_a_r[7:0] <= reg_wdata_i;
            if (wr_b)
                cfg_b_r[7:0] <= reg_wdata_i;
        end
        else if (reg_wr_i && reg_addr_i == `ADDR_VALUE)
        begin
            if (wr_a)
                cfg_a_r[9:8] <= reg_wdata_i[1:0];
            if (wr_b)
                cfg_b_r[9:8] <= reg_wdata_i[1:0];
        end
    end

    // ------------------------------------------------------------
    // Timing sources
    // ------------------------------------------------------------
    logic [11:0] int_cnt_r;
    logic [11:0] div_cur;
    logic        int_tick;
    logic        ref_coax_sel;
    logic        ref_ok;
    logic        ref_rise;
    logic        ref_wck_r;
    logic [7:0]  ref_edges_r;
    logic [5:0]  aes_cnt_r;
    logic        ref_tick;
    logic        in_tick;

    assign div_cur  = sync_r[`SYNC_RATE_BIT] ? 12'(`DIV_44K1) : 12'(`DIV_48K);
    assign int_tick = (int_cnt_r == 12'h000);
    assign ref_coax_sel = ~pres_w[0];
    assign ref_ok   = pres_w[0] | pres_w[1];
    assign ref_rise = ref_coax_sel ? rise_w[1] : rise_w[0];
    assign ref_tick = ref_wck_r ? ref_rise :
                      (ref_rise && aes_cnt_r == 6'(`AES_RISE_PER_FRAME - 1));
    assign in_tick  = rise_w[2];

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            int_cnt_r <= 12'h000;
        else if (int_tick)
            int_cnt_r <= div_cur - 12'h001;
        else
            int_cnt_r <= int_cnt_r - 12'h001;
    end

    // Word clock gives a few edges per frame, a biphase reference many
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ref_edges_r <= 8'h00;
            ref_wck_r   <= 1'b0;
        end
        else if (int_tick)
        begin
            ref_edges_r <= 8'h00;
            ref_wck_r   <= ref_edges_r < 8'(`AES_MIN_EDGES);
        end
        else if ((ref_coax_sel ? edge_w[1] : edge_w[0]) && ref_edges_r != 8'hFF)
            ref_edges_r <= ref_edges_r + 8'h01;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            aes_cnt_r <= 6'h00;
        else if (ref_rise)
            aes_cnt_r <= aes_cnt_r + 6'h01;
    end

    // ------------------------------------------------------------
    // Running source selection
    // ------------------------------------------------------------
    sync_mode_t run_src_r;
    logic       run_ok;
    logic       des_ok;
    logic       frame_tick;

    assign des_ok = (mode_sel == SYNC_REF) ? ref_ok :
                    (mode_sel == SYNC_INPUT) ? pres_w[2] : 1'b1;
    assign run_ok = (run_src_r == SYNC_REF) ? ref_ok :
                    (run_src_r == SYNC_INPUT) ? pres_w[2] : 1'b1;
    assign frame_tick = (run_src_r == SYNC_REF) ? ref_tick :
                        (run_src_r == SYNC_INPUT) ? in_tick : int_tick;

    // A lost source gives no further boundary, so fall back at once
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            run_src_r <= SYNC_INT;
        else if (!run_ok)
            run_src_r <= SYNC_INT;
        else if (frame_tick)
        begin
            case (des_ok)
                1'b1:    run_src_r <= mode_sel;
                default: run_src_r <= SYNC_INT;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Waveform state
    // ------------------------------------------------------------
    logic [7:0]  phase_r;
    logic [7:0]  pcnt_r;
    logic [22:0] lfsr_r;

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            phase_r <= 8'h00;
            pcnt_r  <= 8'h00;
        end
        else if (frame_tick)
        begin
            phase_r <= phase_r + 8'h01;
            pcnt_r  <= (pcnt_r == 8'(`PULSE_PERIOD - 1)) ? 8'h00 : pcnt_r + 8'h01;
        end
    end

    // x^23 + x^18 + 1 is maximal length
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            lfsr_r <= `PRS_SEED;
        else if (frame_tick)
            lfsr_r <= {lfsr_r[21:0], lfsr_r[22] ^ lfsr_r[17]};
    end

    function automatic logic [23:0] wave(input sub_cfg_t c, input logic [7:0] ph,
                                         input logic [7:0] pc, input logic [22:0] lf);
        logic [6:0]  x;
        logic [13:0] p;
        logic        in_pulse;
        x = ph[6:0];
        p = 14'(x * (7'h7F - x));
        in_pulse = pc <= {6'h00, c.width_m1};
        wave = 24'h00_0000;
        if (c.channel_test_generator)
        begin
            case (c.func)
                3'd0:    wave = ph[0] ? (ph[1] ? `FS_NEG : `FS_POS) : 24'h00_0000;
                3'd1:    wave = {lf, 1'b0};
                default: wave = (ph[1] ? -`JT_LEVEL : `JT_LEVEL) | {23'h0, pc >= 8'd96};
            endcase
        end
        else
        begin
            case (c.func)
                3'd0:    wave = ph[7] ? -{1'b0, p, 9'h000} : {1'b0, p, 9'h000};
                3'd1:    wave = ph[7] ? `FS_NEG : `FS_POS;
                3'd2:    wave = {ph[7] ? ~x : x, 17'h0_0000} ^ 24'h80_0000;
                3'd3:    wave = {~ph, 16'h0000} ^ 24'h80_0000;
                3'd4:
                begin
                    if (in_pulse)
                    begin
                        case (c.pol)
                            POL_POS: wave = `FS_POS;
                            POL_NEG: wave = `FS_NEG;
                            default: wave = pc[0] ? `FS_NEG : `FS_POS;
                        endcase
                    end
                end
                default: wave = (ph[1] ? -`JT_LEVEL : `JT_LEVEL) | {23'h0, pc >= 8'd96};
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Edit muxing and output stream
    // ------------------------------------------------------------
    logic      en_aud;
    logic      en_cs;
    logic      en_v;
    logic      pass;
    sub_cfg_t  cfg_b_eff;
    subframe_t gen_a;
    subframe_t gen_b;
    frame_t    tx_r;
    logic      strobe_r;

    assign pass      = (run_src_r == SYNC_INPUT);
    assign en_aud    = channel_test_generator ? ~pass : edit_r[`EDIT_AUD_BIT];
    assign en_cs     = channel_test_generator ? ~pass : edit_r[`EDIT_CS_BIT];
    assign en_v      = channel_test_generator ? ~pass : edit_r[`EDIT_V_BIT];
    assign cfg_b_eff = split_eff ? cfg_b_r : cfg_a_r;
    assign gen_a     = '{wave(cfg_a_r, phase_r, pcnt_r, lfsr_r), cfg_a_r.cs_val,
                         cfg_a_r.v_val & ~channel_test_generator};
    assign gen_b     = '{wave(cfg_b_eff, phase_r, pcnt_r, lfsr_r), cfg_b_eff.cs_val,
                         cfg_b_eff.v_val & ~channel_test_generator};

    function automatic subframe_t pick(input subframe_t g, input subframe_t rx,
                                       input logic ps, input logic ea,
                                       input logic ec, input logic ev);
        pick.audio = ea ? g.audio : (ps ? rx.audio : 24'h00_0000);
        pick.cs    = ec ? g.cs : (ps & rx.cs);
        pick.v     = ev ? g.v : (ps & rx.v);
    endfunction

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tx_r     <= '0;
            strobe_r <= 1'b0;
        end
        else
        begin
            strobe_r <= frame_tick;
            if (frame_tick)
            begin
                tx_r.a <= pick(gen_a, rx_data_i.a, pass, en_aud, en_cs, en_v);
                tx_r.b <= pick(gen_b, rx_data_i.b, pass, en_aud, en_cs, en_v);
            end
        end
    end

    assign tx_data_o   = tx_r;
    assign tx_strobe_o = strobe_r;

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    logic [7:0] rdata_r;
    sub_cfg_t   cfg_rd;

    assign cfg_rd = (split_eff && channel_select_b) ? cfg_b_r : cfg_a_r;

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_r <= 8'h00;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                `ADDR_SYNC:   rdata_r <= sync_r;
                `ADDR_EDIT:   rdata_r <= edit_r;
                `ADDR_FUNC:   rdata_r <= cfg_rd[7:0];
                `ADDR_VALUE:  rdata_r <= {6'h00, cfg_rd[9:8]};
                `ADDR_STATUS: rdata_r <= {2'b00, pres_w[2], run_src_r, ref_wck_r,
                                          pres_w[1], pres_w[0]};
                default:      rdata_r <= 8'h00;
            endcase
        end
        else
            rdata_r <= 8'h00;
    end

    assign reg_rdata_o = rdata_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    logic [11:0] gap_r;
    logic [11:0] div_prev_r;
    logic        gap_ok_r;

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            gap_r      <= 12'h000;
            div_prev_r <= 12'h000;
            gap_ok_r   <= 1'b0;
        end
        else if (int_tick)
        begin
            gap_r      <= 12'h001;
            div_prev_r <= div_cur;
            gap_ok_r   <= 1'b1;
        end
        else
            gap_r <= gap_r + 12'h001;
    end

    property p_int_rate;
        int_tick && gap_ok_r |-> gap_r == div_prev_r;
    endproperty
    a_int_rate: assert property (p_int_rate) else $error("internal rate period wrong");

    property p_fallback;
        mode_sel != SYNC_INT && !des_ok && run_src_r == mode_sel |=> run_src_r == SYNC_INT;
    endproperty
    a_fallback: assert property (p_fallback) else $error("no fallback to internal");

    property p_boundary;
        run_src_r != $past(run_src_r) && $past(run_ok) |-> $past(frame_tick);
    endproperty
    a_boundary: assert property (p_boundary) else $error("source switched mid frame");

    property p_clear;
        clr_wr |=> sync_r == `SYNC_RST && edit_r == `EDIT_RST;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not restore defaults");

    property p_copy;
        reg_wr_i && reg_addr_i == `ADDR_EDIT && !channel_test_generator &&
        reg_wdata_i[0] != edit_r[0] |=> cfg_b_r == $past(cfg_a_r);
    endproperty
    a_copy: assert property (p_copy) else $error("A set not copied to B");

    property p_black;
        frame_tick && !pass && !en_aud |=> tx_r.a.audio == 24'h0 && tx_r.b.audio == 24'h0;
    endproperty
    a_black: assert property (p_black) else $error("disabled audio not zero");

    property p_pass;
        frame_tick && pass && !en_cs |=> tx_r.a.cs == $past(rx_data_i.a.cs) &&
                                         tx_r.b.cs == $past(rx_data_i.b.cs);
    endproperty
    a_pass: assert property (p_pass) else $error("received data not forwarded");

    property p_channel_test_generator;
        channel_test_generator |-> !split_eff && en_aud == !pass && en_v == !pass;
    endproperty
    a_channel_test_generator: assert property (p_channel_test_generator) else $error("second generator not locked");

    property p_pulse_wrap;
        frame_tick && pcnt_r == 8'd191 |=> pcnt_r == 8'd0 ##1 pcnt_r == 8'd0 [*1];
    endproperty
    a_pulse_wrap: assert property (p_pulse_wrap) else $error("pulse period not 192");

    property p_lfsr;
        frame_tick |=> lfsr_r != 23'h0 && lfsr_r != $past(lfsr_r);
    endproperty
    a_lfsr: assert property (p_lfsr) else $error("sequence stuck");

    property p_tied;
        frame_tick && !split_eff && !pass |=> tx_r.a == tx_r.b;
    endproperty
    a_tied: assert property (p_tied) else $error("tied subframes differ");

    c_input_run: cover property (run_src_r == SYNC_INPUT && frame_tick);
    c_ref_wck:   cover property (run_src_r == SYNC_REF && ref_wck_r && frame_tick);
    c_pulse:     cover property (frame_tick && cfg_a_r.func == 3'd4 && in_tick);
    c_channel_test_generator_prs:  cover property (frame_tick && channel_test_generator && cfg_a_r.func == 3'd1);

endmodule // audio_generator_editor_control
